/* File: hw/fbn_regs.vh */
// register map, status bits, feature positions and reset values of the feature negotiation block
`ifndef FBN_REGS_VH
`define FBN_REGS_VH

// ==========================================================
// widths
`define FBN_ADDR_W 8
`define FBN_WORD_W 32
`define FBN_FEAT_W 64
`define FBN_STAT_W 8

// ==========================================================
// register byte offsets
`define FBN_OFF_DEV_SEL 8'h00
`define FBN_OFF_DEV_FEAT 8'h04
`define FBN_OFF_DRV_SEL 8'h08
`define FBN_OFF_DRV_FEAT 8'h0c
`define FBN_OFF_STATUS 8'h10
`define FBN_OFF_NEG_LO 8'h14
`define FBN_OFF_NEG_HI 8'h18
`define FBN_OFF_INFO 8'h1c

// ==========================================================
// device status bits
`define FBN_ST_ACK 0
`define FBN_ST_DRIVER 1
`define FBN_ST_DRIVER_OK 2
`define FBN_ST_FEATURES_OK 3
`define FBN_ST_NEEDS_RESET 6
`define FBN_ST_FAILED 7

// ==========================================================
// info register bits
`define FBN_INFO_SRIOV_ONCE 0
`define FBN_INFO_EMULATION 1
`define FBN_INFO_REFUSED 2
`define FBN_INFO_VF_ENABLED 3

// ==========================================================
// feature bit positions
`define FBN_F_NOTIFY_ON_EMPTY 24
`define FBN_F_ANY_LAYOUT 27
`define FBN_F_UNUSED30 30
`define FBN_F_VERSION_1 32
`define FBN_F_ACCESS_PLATFORM 33
`define FBN_F_RING_PACKED 34
`define FBN_F_IN_ORDER 35
`define FBN_F_ORDER_PLATFORM 36
`define FBN_F_SR_IOV 37

// ==========================================================
// reset values
`define FBN_STATUS_RST 8'h00
`define FBN_WORD_RST 32'h0000_0000
`define FBN_FEAT_RST 64'h0000_0000_0000_0000
`define FBN_SEL_RST 1'b0

`endif

/* File: hw/fbn_order_track.v */
// buffer sequencing for one queue: in-order consumption, pending count and queue-empty event
`timescale 1ns/1ps
module fbn_order_track #(
	parameter IDX_W = 16
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire clear_i,
	input wire in_order_i,
	input wire avail_push_i,
	input wire use_req_i,
	input wire [IDX_W-1:0] use_idx_i,
	output wire use_ok_o,
	output reg [IDX_W-1:0] head_idx_o,
	output reg [IDX_W-1:0] pending_o,
	output reg empty_evt_o
);

	wire have_buf;
	wire take;
	reg [IDX_W-1:0] next_pending;

	// ==========================================================
	// acceptance
	// slots are made available in ring order, so the oldest one is the head counter
	assign have_buf = (pending_o != {IDX_W{1'b0}});
	assign use_ok_o = have_buf & (~in_order_i | (use_idx_i == head_idx_o)); // (R9)
	assign take = use_req_i & use_ok_o;

	// pending count: a push and a use in the same cycle cancel out
	always @* begin
		next_pending = pending_o;
		if (avail_push_i & ~take) begin
			next_pending = pending_o + {{(IDX_W-1){1'b0}}, 1'b1};
		end else if (take & ~avail_push_i) begin
			next_pending = pending_o - {{(IDX_W-1){1'b0}}, 1'b1};
		end
	end

	// ==========================================================
	// state
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			head_idx_o <= {IDX_W{1'b0}};
			pending_o <= {IDX_W{1'b0}};
			empty_evt_o <= 1'b0;
		end else if (clear_i) begin
			head_idx_o <= {IDX_W{1'b0}};
			pending_o <= {IDX_W{1'b0}};
			empty_evt_o <= 1'b0;
		end else begin
			pending_o <= next_pending;
			empty_evt_o <= take & (next_pending == {IDX_W{1'b0}}); // (R15)
			if (take) begin
				head_idx_o <= head_idx_o + {{(IDX_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

/* File: hw/fbn_feature_neg.v */
// feature negotiation top: offered word, driver acceptance, status handshake and feature effects
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "fbn_regs.vh"

// Operation
// (R1) Driver accepts version-1 compliance whenever offered; may stop otherwise.
// (R2) Device always offers version-1; may fail if driver refuses it.
// (R3) Driver should accept platform access and then set up address translation.
// (R4) Without platform access offered, driver passes only physical addresses.
// (R5) Device offers platform access when memory is translated; may fail if refused.
// (R6) Driver should accept packed ring whenever offered.
// (R7) Driver should accept platform ordering and then use hardware barriers.
// (R8) Refused platform ordering: device fails or runs slower emulation mode.
// (R9) With in-order negotiated, buffers are used in availability order.
// (R10) Add-in PCI card offers both platform access and platform ordering.
// (R11) SR-IOV offered only by PCI device with SR-IOV capability.
// (R12) Driver never negotiates SR-IOV on non-PCI or capability-less devices.
// (R13) Driver negotiates SR-IOV and completes negotiation before enabling functions.
// (R14) After one SR-IOV negotiation, function enables are honoured across resets.
// (R15) Notify-on-empty at bit 24 forces notification when queue empties.
// (R16) Transitional device offers any-layout at bit 27; driver accepts it.
// (R17) Bit 30 is never offered nor negotiated.
// (R18) Version-1 compliance sits at feature bit 32.
// (R19) Platform access sits at bit 33; clear means untranslated physical addresses.
// (R20) In-order buffer use sits at feature bit 35.
// (R21) SR-IOV sits at feature bit 37, PCI devices only.
// (R22) Negotiated bits are exactly offered bits that the driver accepted.
module fbn_feature_neg #(
	parameter IDX_W = 16,
	parameter TRANSITIONAL = 1,
	parameter OFFER_NOTIFY_ON_EMPTY = 1,
	parameter OFFER_RING_PACKED = 1,
	parameter OFFER_IN_ORDER = 1,
	parameter TRANSLATED_ACCESS = 1,
	parameter PCI_ADDIN_CARD = 1,
	parameter OFFER_ORDER_PLATFORM = 0,
	parameter IS_PCI = 1,
	parameter HAS_SRIOV_CAP = 0,
	parameter FAIL_ON_VERSION_REFUSED = 1,
	parameter FAIL_ON_ACCESS_REFUSED = 1,
	parameter FAIL_ON_ORDER_REFUSED = 0
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire [`FBN_ADDR_W-1:0] reg_addr_i,
	input wire [`FBN_WORD_W-1:0] reg_wdata_i,
	input wire reg_we_i,
	input wire reg_re_i,
	output reg [`FBN_WORD_W-1:0] reg_rdata_o,
	input wire sys_reset_i,
	input wire vf_enable_req_i,
	output reg vf_enable_o,
	input wire avail_push_i,
	input wire use_req_i,
	input wire [IDX_W-1:0] use_idx_i,
	output wire use_ok_o,
	output wire [IDX_W-1:0] head_idx_o,
	output wire [IDX_W-1:0] pending_o,
	input wire notify_suppress_i,
	output reg notify_o,
	output reg [`FBN_FEAT_W-1:0] negotiated_o,
	output wire features_ok_o,
	output wire failed_o,
	output reg emulation_o
);

	// ==========================================================
	// offered feature word, fixed by the build
	wire [`FBN_FEAT_W-1:0] offered;
	wire offer_access;
	wire offer_order;
	wire offer_sriov;

	assign offer_access = (TRANSLATED_ACCESS != 0) | (PCI_ADDIN_CARD != 0); // (R5) (R10)
	assign offer_order = (OFFER_ORDER_PLATFORM != 0) | (PCI_ADDIN_CARD != 0); // (R10)
	assign offer_sriov = (IS_PCI != 0) & (HAS_SRIOV_CAP != 0); // (R11) (R21)

	// every bit not named here stays zero, bit 30 included
	genvar gi;
	generate
		for (gi = 0; gi < `FBN_FEAT_W; gi = gi + 1) begin : g_offer
			if (gi == `FBN_F_VERSION_1) begin : g_v1
				assign offered[gi] = 1'b1; // (R2) (R18)
			end else if (gi == `FBN_F_ACCESS_PLATFORM) begin : g_ap
				assign offered[gi] = offer_access; // (R19)
			end else if (gi == `FBN_F_RING_PACKED) begin : g_rp
				assign offered[gi] = (OFFER_RING_PACKED != 0);
			end else if (gi == `FBN_F_IN_ORDER) begin : g_io
				assign offered[gi] = (OFFER_IN_ORDER != 0); // (R20)
			end else if (gi == `FBN_F_ORDER_PLATFORM) begin : g_op
				assign offered[gi] = offer_order;
			end else if (gi == `FBN_F_SR_IOV) begin : g_sr
				assign offered[gi] = offer_sriov;
			end else if (gi == `FBN_F_NOTIFY_ON_EMPTY) begin : g_ne
				assign offered[gi] = (TRANSITIONAL != 0) & (OFFER_NOTIFY_ON_EMPTY != 0); // (R15)
			end else if (gi == `FBN_F_ANY_LAYOUT) begin : g_al
				assign offered[gi] = (TRANSITIONAL != 0); // (R16)
			end else begin : g_none
				assign offered[gi] = 1'b0; // (R17)
			end
		end
	endgenerate

	// ==========================================================
	// register state
	reg dev_sel;
	reg drv_sel;
	reg [`FBN_FEAT_W-1:0] accepted;
	reg [`FBN_STAT_W-1:0] status;
	reg sriov_once;
	reg refused;

	// ==========================================================
	// address decode
	wire hit_dev_sel = (reg_addr_i == `FBN_OFF_DEV_SEL);
	wire hit_drv_sel = (reg_addr_i == `FBN_OFF_DRV_SEL);
	wire hit_drv_feat = (reg_addr_i == `FBN_OFF_DRV_FEAT);
	wire hit_status = (reg_addr_i == `FBN_OFF_STATUS);
	wire wr_drv_feat = reg_we_i & hit_drv_feat & ~status[`FBN_ST_FEATURES_OK];
	wire wr_status = reg_we_i & hit_status;
	wire dev_reset = (wr_status & (reg_wdata_i == `FBN_WORD_RST)) | sys_reset_i;

	// ==========================================================
	// acceptance check at the features-ok request
	// a bit the device never offered cannot become negotiated
	wire [`FBN_FEAT_W-1:0] next_neg = offered & accepted; // (R22)
	wire miss_v1 = ~next_neg[`FBN_F_VERSION_1] & (FAIL_ON_VERSION_REFUSED != 0); // (R2)
	wire miss_ap = offered[`FBN_F_ACCESS_PLATFORM] & ~next_neg[`FBN_F_ACCESS_PLATFORM]
		& (FAIL_ON_ACCESS_REFUSED != 0); // (R5)
	wire miss_op = offered[`FBN_F_ORDER_PLATFORM] & ~next_neg[`FBN_F_ORDER_PLATFORM]
		& (FAIL_ON_ORDER_REFUSED != 0); // (R8)
	wire fok_req = wr_status & reg_wdata_i[`FBN_ST_FEATURES_OK] & ~status[`FBN_ST_FEATURES_OK];
	wire fok_grant = fok_req & ~(miss_v1 | miss_ap | miss_op);

	assign features_ok_o = status[`FBN_ST_FEATURES_OK];
	assign failed_o = status[`FBN_ST_NEEDS_RESET];

	// ==========================================================
	// selectors and driver acceptance words
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dev_sel <= `FBN_SEL_RST;
			drv_sel <= `FBN_SEL_RST;
			accepted <= `FBN_FEAT_RST;
		end else if (dev_reset) begin
			accepted <= `FBN_FEAT_RST;
		end else begin
			if (reg_we_i & hit_dev_sel) begin
				dev_sel <= reg_wdata_i[0];
			end
			if (reg_we_i & hit_drv_sel) begin
				drv_sel <= reg_wdata_i[0];
			end
			// the word is frozen once negotiation has been confirmed
			if (wr_drv_feat & drv_sel) begin
				accepted[`FBN_FEAT_W-1:`FBN_WORD_W] <= reg_wdata_i;
			end else if (wr_drv_feat) begin
				accepted[`FBN_WORD_W-1:0] <= reg_wdata_i;
			end
		end
	end

	// ==========================================================
	// status handshake and negotiated word
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status <= `FBN_STATUS_RST;
			negotiated_o <= `FBN_FEAT_RST;
			refused <= 1'b0;
			emulation_o <= 1'b0;
		end else if (dev_reset) begin
			status <= `FBN_STATUS_RST;
			negotiated_o <= `FBN_FEAT_RST;
			refused <= 1'b0;
			emulation_o <= 1'b0;
		end else if (wr_status) begin
			status[`FBN_ST_ACK] <= reg_wdata_i[`FBN_ST_ACK];
			status[`FBN_ST_DRIVER] <= reg_wdata_i[`FBN_ST_DRIVER];
			status[`FBN_ST_FAILED] <= reg_wdata_i[`FBN_ST_FAILED];
			// driver-ok only counts after features-ok has stuck
			status[`FBN_ST_DRIVER_OK] <= reg_wdata_i[`FBN_ST_DRIVER_OK] & status[`FBN_ST_FEATURES_OK];
			if (fok_grant) begin
				status[`FBN_ST_FEATURES_OK] <= 1'b1;
				negotiated_o <= next_neg; // (R22)
				emulation_o <= offered[`FBN_F_ORDER_PLATFORM] & ~next_neg[`FBN_F_ORDER_PLATFORM]; // (R8)
			end else if (fok_req) begin
				// features-ok reads back clear and the device stops
				status[`FBN_ST_NEEDS_RESET] <= 1'b1; // (R2) (R5) (R8)
				refused <= 1'b1;
			end
		end
	end

	// ==========================================================
	// sr-iov history and function enable
	// only power-on reset forgets a past negotiation; device and system resets keep it
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sriov_once <= 1'b0;
			vf_enable_o <= 1'b0;
		end else begin
			if (fok_grant & next_neg[`FBN_F_SR_IOV]) begin
				sriov_once <= 1'b1; // (R14)
			end
			vf_enable_o <= vf_enable_req_i & sriov_once; // (R13) (R14)
		end
	end

	// ==========================================================
	// queue sequencing and used-buffer notification
	wire empty_evt;
	wire in_order_on = negotiated_o[`FBN_F_IN_ORDER] & status[`FBN_ST_FEATURES_OK];
	wire take = use_req_i & use_ok_o;

	fbn_order_track #(
		.IDX_W(IDX_W)
	) u_track (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(dev_reset),
		.in_order_i(in_order_on),
		.avail_push_i(avail_push_i),
		.use_req_i(use_req_i),
		.use_idx_i(use_idx_i),
		.use_ok_o(use_ok_o),
		.head_idx_o(head_idx_o),
		.pending_o(pending_o),
		.empty_evt_o(empty_evt)
	); // (R9)

	// the empty event overrides suppression; a normal use only notifies when allowed
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			notify_o <= 1'b0;
		end else begin
			notify_o <= (take & ~notify_suppress_i)
				| (empty_evt & negotiated_o[`FBN_F_NOTIFY_ON_EMPTY]); // (R15)
		end
	end

	// ==========================================================
	// read port: data stands only in the cycle after the strobe
	reg [`FBN_WORD_W-1:0] rd_mux;
	always @* begin
		rd_mux = `FBN_WORD_RST;
		if (reg_addr_i == `FBN_OFF_DEV_SEL) begin
			rd_mux = {{(`FBN_WORD_W-1){1'b0}}, dev_sel};
		end else if (reg_addr_i == `FBN_OFF_DEV_FEAT) begin
			rd_mux = dev_sel ? offered[`FBN_FEAT_W-1:`FBN_WORD_W] : offered[`FBN_WORD_W-1:0];
		end else if (reg_addr_i == `FBN_OFF_DRV_SEL) begin
			rd_mux = {{(`FBN_WORD_W-1){1'b0}}, drv_sel};
		end else if (reg_addr_i == `FBN_OFF_DRV_FEAT) begin
			rd_mux = drv_sel ? accepted[`FBN_FEAT_W-1:`FBN_WORD_W] : accepted[`FBN_WORD_W-1:0];
		end else if (reg_addr_i == `FBN_OFF_STATUS) begin
			rd_mux = {{(`FBN_WORD_W-`FBN_STAT_W){1'b0}}, status};
		end else if (reg_addr_i == `FBN_OFF_NEG_LO) begin
			rd_mux = negotiated_o[`FBN_WORD_W-1:0];
		end else if (reg_addr_i == `FBN_OFF_NEG_HI) begin
			rd_mux = negotiated_o[`FBN_FEAT_W-1:`FBN_WORD_W];
		end else if (reg_addr_i == `FBN_OFF_INFO) begin
			rd_mux[`FBN_INFO_SRIOV_ONCE] = sriov_once;
			rd_mux[`FBN_INFO_EMULATION] = emulation_o;
			rd_mux[`FBN_INFO_REFUSED] = refused;
			rd_mux[`FBN_INFO_VF_ENABLED] = vf_enable_o;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= `FBN_WORD_RST;
		end else if (reg_re_i) begin
			reg_rdata_o <= rd_mux;
		end else begin
			reg_rdata_o <= `FBN_WORD_RST;
		end
	end

endmodule

/* File: sim/fbn_neg_props.sv */
// assertion checker for the feature negotiation block
`timescale 1ns/1ps
module fbn_neg_props #(
	parameter IDX_W = 16
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire reg_we_i,
	input wire sys_reset_i,
	input wire vf_enable_req_i,
	input wire vf_enable_o,
	input wire avail_push_i,
	input wire use_req_i,
	input wire use_ok_o,
	input wire [IDX_W-1:0] head_idx_o,
	input wire [IDX_W-1:0] pending_o,
	input wire notify_suppress_i,
	input wire notify_o,
	input wire [63:0] negotiated_o,
	input wire features_ok_o,
	input wire failed_o,
	input wire emulation_o
);
	wire take = use_req_i & use_ok_o;
	// register writes and partial resets may clear the queue, so the head, pending and notify-use checks skip them
	wire quiet = !sys_reset_i && !reg_we_i;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ==========================================================
	// negotiation outcome
	ok_fail_excl_a: assert property (!(features_ok_o && failed_o))
		else $error("features ok and failed at once");
	ok_needs_v1_a: assert property (features_ok_o |-> negotiated_o[32])
		else $error("features ok without version one");
	low_reserved_a: assert property (negotiated_o[31:28] == 4'h0)
		else $error("unoffered low bit negotiated");
	emul_mode_a: assert property (emulation_o |-> features_ok_o && !negotiated_o[36])
		else $error("emulation without refused ordering");
	// ==========================================================
	// queue order and notification
	use_gate_a: assert property (use_ok_o |-> pending_o != 0)
		else $error("use granted on empty queue");
	head_step_a: assert property (take && quiet |=> head_idx_o == $past(head_idx_o) + 1'b1)
		else $error("head did not advance");
	pend_push_a: assert property (avail_push_i && !take && quiet |=> pending_o == $past(pending_o) + 1'b1)
		else $error("pending did not grow");
	notify_use_a: assert property (take && quiet && !notify_suppress_i |=> notify_o)
		else $error("missing notification");
	notify_cause_a: assert property (notify_o |-> ($past(use_req_i) && $past(use_ok_o))
		|| ($past(use_req_i, 2) && $past(use_ok_o, 2)))
		else $error("notification without use");
	// ==========================================================
	// virtual functions
	vf_cause_a: assert property (vf_enable_o |-> $past(vf_enable_req_i))
		else $error("function enable without request");
	vf_keep_a: assert property (sys_reset_i && vf_enable_req_i && vf_enable_o |=> vf_enable_o)
		else $error("function enable lost on reset");
endmodule
bind fbn_feature_neg fbn_neg_props #(.IDX_W(IDX_W)) u_props (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_we_i(reg_we_i), .sys_reset_i(sys_reset_i),
	.vf_enable_req_i(vf_enable_req_i), .vf_enable_o(vf_enable_o), .avail_push_i(avail_push_i),
	.use_req_i(use_req_i), .use_ok_o(use_ok_o), .head_idx_o(head_idx_o), .pending_o(pending_o),
	.notify_suppress_i(notify_suppress_i), .notify_o(notify_o), .negotiated_o(negotiated_o),
	.features_ok_o(features_ok_o), .failed_o(failed_o), .emulation_o(emulation_o)
);

/* File: sim/fbn_drv_model.sv */
// host driver model: register access and feature acceptance
`timescale 1ns/1ps
`include "fbn_regs.vh"
module fbn_drv_model (
	input wire core_clk_i,
	input wire [31:0] reg_rdata_i,
	output reg [7:0] reg_addr_o,
	output reg [31:0] reg_wdata_o,
	output reg reg_we_o,
	output reg reg_re_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 32'h0;
		reg_we_o = 1'b0;
		reg_re_o = 1'b0;
	end
	// address and data are inverted after release so a stale value never looks valid
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk_i);
			reg_addr_o <= a;
			reg_wdata_o <= d;
			reg_we_o <= 1'b1;
			@(posedge core_clk_i);
			reg_we_o <= 1'b0;
			reg_addr_o <= ~a;
			reg_wdata_o <= ~d;
		end
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input [7:0] a, output [31:0] d);
		begin
			@(posedge core_clk_i);
			reg_addr_o <= a;
			reg_re_o <= 1'b1;
			@(posedge core_clk_i);
			reg_re_o <= 1'b0;
			reg_addr_o <= ~a;
			#1;
			d = reg_rdata_i;
		end
	endtask
	// a 64-bit acceptance goes as two halves through the select register
	task accept(input [31:0] lo, input [31:0] hi);
		begin
			wr(`FBN_OFF_DRV_SEL, 32'h0);
			wr(`FBN_OFF_DRV_FEAT, lo);
			wr(`FBN_OFF_DRV_SEL, 32'h1);
			wr(`FBN_OFF_DRV_FEAT, hi);
		end
	endtask
endmodule

/* File: sim/tb_fbn_feature_neg.sv */
// self-checking bench for the feature negotiation block
`timescale 1ns/1ps
`include "fbn_regs.vh"
module tb_fbn_feature_neg;
	reg core_clk_i = 1'b0;
	reg reset_n_i = 1'b0;
	reg sys_reset_i = 1'b0;
	reg vf_enable_req_i = 1'b0;
	reg avail_push_i = 1'b0;
	reg use_req_i = 1'b0;
	reg [15:0] use_idx_i = 16'h0000;
	reg notify_suppress_i = 1'b0;
	wire [7:0] addr;
	wire [31:0] wdata, rdata;
	wire we, re, vf_en, use_ok, notify, feat_ok, failed, emul;
	wire [15:0] head, pending;
	wire [63:0] neg;
	integer err_count = 0;
	integer check_count = 0;
	reg [31:0] rv;
	fbn_feature_neg #(.HAS_SRIOV_CAP(1)) dut (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .sys_reset_i(sys_reset_i),
		.vf_enable_req_i(vf_enable_req_i), .vf_enable_o(vf_en), .avail_push_i(avail_push_i),
		.use_req_i(use_req_i), .use_idx_i(use_idx_i), .use_ok_o(use_ok), .head_idx_o(head),
		.pending_o(pending), .notify_suppress_i(notify_suppress_i), .notify_o(notify),
		.negotiated_o(neg), .features_ok_o(feat_ok), .failed_o(failed), .emulation_o(emul)
	);
	fbn_drv_model drv (
		.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wdata_o(wdata),
		.reg_we_o(we), .reg_re_o(re)
	);
	initial forever #5 core_clk_i = ~core_clk_i;
	task chk_w(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH %0t word %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chk_b(input got, input exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH %0t flag %b expected %b", $time, got, exp);
			end
		end
	endtask
	task rd_chk(input [7:0] a, input [31:0] exp);
		begin
			drv.rd(a, rv);
			chk_w(rv, exp);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// a hang counts as a failure
	initial begin
		#100000;
		err_count = err_count + 1;
		finish_test;
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		// offered word: bits 24 and 27 low, 32 to 37 high, never bit 30
		drv.wr(`FBN_OFF_DEV_SEL, 32'h0);
		rd_chk(`FBN_OFF_DEV_FEAT, 32'h0900_0000);
		drv.wr(`FBN_OFF_DEV_SEL, 32'h1);
		rd_chk(`FBN_OFF_DEV_FEAT, 32'h0000_003f);
		rd_chk(8'h40, 32'h0);
		// withholding version one must be refused
		drv.accept(32'h0, 32'h2);
		drv.wr(`FBN_OFF_STATUS, 32'h0b);
		rd_chk(`FBN_OFF_STATUS, 32'h43);
		chk_b(failed, 1'b1);
		drv.wr(`FBN_OFF_STATUS, 32'h0);
		rd_chk(`FBN_OFF_STATUS, 32'h0);
		// all but platform ordering, plus unoffered bits 30 and 31
		drv.accept(32'hc900_0000, 32'h2f);
		drv.wr(`FBN_OFF_STATUS, 32'h0b);
		rd_chk(`FBN_OFF_STATUS, 32'h0b);
		rd_chk(`FBN_OFF_NEG_LO, 32'h0900_0000);
		rd_chk(`FBN_OFF_NEG_HI, 32'h2f);
		chk_w(neg[63:32], 32'h2f);
		chk_b(emul, 1'b1);
		rd_chk(`FBN_OFF_INFO, 32'h3);
		drv.wr(`FBN_OFF_DRV_FEAT, 32'h0);
		rd_chk(`FBN_OFF_DRV_FEAT, 32'h2f);
		// in-order queue: slot 1 is refused while slot 0 is oldest
		@(posedge core_clk_i);
		avail_push_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		avail_push_i <= 1'b0;
		use_req_i <= 1'b1;
		use_idx_i <= 16'h0001;
		#1;
		chk_w({16'h0, pending}, 32'h2);
		chk_b(use_ok, 1'b0);
		@(posedge core_clk_i);
		use_idx_i <= 16'h0000;
		#1;
		chk_b(use_ok, 1'b1);
		@(posedge core_clk_i);
		use_req_i <= 1'b0;
		notify_suppress_i <= 1'b1;
		#1;
		chk_w({head, pending}, 32'h0001_0001);
		chk_b(notify, 1'b1);
		// suppressed, yet emptying the queue still notifies
		@(posedge core_clk_i);
		use_req_i <= 1'b1;
		use_idx_i <= 16'h0001;
		@(posedge core_clk_i);
		use_req_i <= 1'b0;
		#1;
		chk_w({head, pending}, 32'h0002_0000);
		// the empty event is registered in the tracker, so its notification lands one cycle later
		@(posedge core_clk_i);
		#1;
		chk_b(notify, 1'b1);
		// enable survives a partial reset once SR-IOV was negotiated
		@(posedge core_clk_i);
		vf_enable_req_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_reset_i <= 1'b1;
		@(posedge core_clk_i);
		sys_reset_i <= 1'b0;
		#1;
		chk_b(feat_ok, 1'b0);
		chk_b(vf_en, 1'b1);
		finish_test;
	end
endmodule
